/* rtl/mfc_pkg.sv */
// Constants, types and helpers for the serial frame check and format block.
// Assumes one 25 MHz clock; characters arrive from a UART on that clock.
// How it works
// (RULE1) ASCII check sums address through last data byte modulo 256.
// (RULE2) ASCII check byte is the negated sum, sent as two hex characters.
// (RULE3) CRC accumulator starts at all ones for every RTU message.
// (RULE4) Each byte is XORed into the low eight accumulator bits first.
// (RULE5) Each step shifts right, zero in; XOR A001 when a one fell out.
// (RULE6) Exactly eight such steps are applied per byte.
// (RULE7) Final accumulator is the CRC, with no inversion.
// (RULE8) CRC goes out low byte first, then high byte.
// (RULE9) Read request: start address and word count; reply: byte count, data.
// (RULE10) Single write carries address and value; reply echoes the frame.
// (RULE11) Multi write carries address, words, bytes, data; reply drops data.
// (RULE12) ASCII frame starts with colon, ends CR LF, bytes as hex pairs.
// (RULE13) RTU messages are bounded by line idle longer than ten ms.
// (RULE14) Station zero is broadcast; the device never replies to it.
// (RULE15) Addresses, counts and data words travel high byte first.
// (RULE16) Frames failing the check are dropped: no action, no reply.
package mfc_pkg;
  localparam logic [7:0]  CH_COLON    = 8'h3a;
  localparam logic [7:0]  CH_CR       = 8'h0d;
  localparam logic [7:0]  CH_LF       = 8'h0a;
  localparam logic [15:0] CRC_PRESET  = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [7:0]  FN_READ     = 8'h03;
  localparam logic [7:0]  FN_WRITE1   = 8'h06;
  localparam logic [7:0]  FN_WRITEN   = 8'h10;
  localparam logic [7:0]  BCAST_ADDR  = 8'h00;
  localparam int          BUF_BYTES   = 20;
  localparam logic [4:0]  BUF_LAST    = 5'h13;
  localparam logic [7:0]  MAX_RD_WDS  = 8'h07;
  localparam logic [7:0]  MAX_WR_WDS  = 8'h05;
  localparam logic [4:0]  RD_DATA_POS = 5'h03;
  localparam logic [4:0]  WR_DATA_POS = 5'h07;
  localparam logic [4:0]  ECHO_LEN    = 5'h06;
  localparam logic [4:0]  MIN_RTU_LEN = 5'h04;
  localparam logic [4:0]  MIN_ASC_LEN = 5'h03;
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          GAP_MS      = 10;
  // Idle must exceed the gap, hence one cycle more
  localparam int          GAP_CYCLES_DEF = GAP_MS * (CLK_HZ / 1000) + 1;
  localparam int          GAP_W       = 18;

  typedef enum logic [3:0] {
    S_RX, S_EXEC, S_WR, S_RD, S_RDW, S_TSOF, S_TDAT, S_TCK, S_TCR, S_TLF
  } mfc_state_e;

  function automatic logic [7:0] nib2asc(input logic [3:0] v);
    return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  // Returns {valid, nibble}; lower-case hex is accepted too
  function automatic logic [4:0] asc2nib(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) r = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      r = {1'b1, c[3:0] + 4'h9};
    return r;
  endfunction
endpackage

/* rtl/mfc_chk_if.sv */
// Link between the frame logic and one check engine.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface mfc_chk_if;
  logic        clr;   // Restart both sums
  logic        en;    // Fold data in this cycle
  logic [7:0]  data;
  logic [15:0] crc;
  logic [7:0]  sum;
  modport eng (input clr, input en, input data, output crc, output sum);
  modport usr (output clr, output en, output data, input crc, input sum);
endinterface

/* rtl/mfc_check_engine.sv */
// Byte-wide CRC and modulo-256 sum engine, one byte per cycle.
// Assumes the user raises clr together with or before the first byte.
`timescale 1ns/100ps
module mfc_check_engine
  import mfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  mfc_chk_if.eng   chk
);
  typedef struct packed {
    logic [15:0] crc;
    logic [7:0]  sum;
  } mfc_eng_s;

  mfc_eng_s q_r;
  mfc_eng_s q_nxt;

  // Whole byte in one cycle; eight steps unrolled by the loop
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] v;
    // (RULE4) fold byte low
    v = c ^ {8'h00, d};
    // (RULE6) eight steps per byte
    for (int i = 0; i < 8; i++) begin
      // (RULE5) shift, conditional XOR
      if (v[0]) v = (v >> 1) ^ CRC_POLY;
      else v = v >> 1;
    end
    return v;
  endfunction

  // Clear and first byte may coincide, so the base is chosen first
  always_comb begin
    mfc_eng_s b;
    b = q_r;
    // (RULE3) preset all ones
    if (chk.clr) b = '{crc: CRC_PRESET, sum: 8'h00};
    q_nxt = b;
    if (chk.en) begin
      q_nxt.crc = crc_byte(b.crc, chk.data);
      // (RULE1) modulo 256 sum
      q_nxt.sum = b.sum + chk.data;
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) q_r <= '{crc: CRC_PRESET, sum: 8'h00};
    else q_r <= q_nxt;
  end

  // (RULE7) value used as is
  assign chk.crc = q_r.crc;
  assign chk.sum = q_r.sum;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_crc_preset: assert property (chk.clr && !chk.en |=> // (RULE3)
    chk.crc == CRC_PRESET)
    else $error("crc not preset after clear");
  a_crc_step: assert property (chk.en && !chk.clr |=>
    chk.crc == crc_byte($past(chk.crc), $past(chk.data))) // (RULE6)
    else $error("crc byte step wrong");
  a_lrc_add: assert property (chk.en && !chk.clr |=>
    chk.sum == 8'($past(chk.sum) + $past(chk.data))) // (RULE1)
    else $error("sum not modulo 256");
  a_sums_hold: assert property (!chk.en && !chk.clr |=>
    $stable(chk.crc) && $stable(chk.sum)) // (RULE7)
    else $error("check value moved while idle");
endmodule // mfc_check_engine

/* rtl/mfc_frame_top.sv */
// Slave frame receive, check, request decode and reply formatting.
// Assumes a UART on i_clk delivers and takes characters (8-bit bytes in
// RTU), and a register file answers o_rd_addr in the same cycle.
`timescale 1ns/100ps
module mfc_frame_top
  import mfc_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYCLES_DEF
)(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_mode_rtu,
  input  wire logic [7:0]  i_station,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_tx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_char,
  output logic             o_wr_valid,
  output logic [15:0]      o_wr_addr,
  output logic [15:0]      o_wr_data,
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_addr,
  input  wire logic [15:0] i_rd_data,
  output logic             o_frame_ok,
  output logic             o_frame_bad
);
  localparam logic [GAP_W-1:0] GAP_END = GAP_W'(GAP_CYCLES);

  typedef struct packed {
    mfc_state_e            st;
    logic [BUF_BYTES-1:0][7:0] buf_b;
    logic [4:0]            idx;    // Bytes received
    logic                  act;    // Inside a frame
    logic                  ovf;
    logic                  half;   // Second hex char pending
    logic [3:0]            hin;
    logic                  cr;
    logic [GAP_W-1:0]      gap;
    logic [15:0]           start;
    logic [3:0]            cnt;
    logic [3:0]            widx;
    logic [4:0]            len;
    logic [4:0]            tpos;
    logic                  ckb;
    logic                  bcast;
    logic                  tx_valid;
    logic [7:0]            tx_char;
    logic                  wr_valid;
    logic [15:0]           wr_addr;
    logic [15:0]           wr_data;
    logic                  rd_valid;
    logic [15:0]           rd_addr;
    logic                  frame_ok;
    logic                  frame_bad;
  } mfc_top_s;

  mfc_top_s q_r;
  mfc_top_s q_nxt;

  mfc_chk_if rx_chk ();
  mfc_chk_if tx_chk ();

  mfc_check_engine u_rx_eng (.i_clk(i_clk), .i_reset(i_reset), .chk(rx_chk));
  mfc_check_engine u_tx_eng (.i_clk(i_clk), .i_reset(i_reset), .chk(tx_chk));

  logic       tx_take;
  logic [7:0] lrc_tx;
  assign tx_take = q_r.tx_valid && i_tx_ready;
  // (RULE2) negated sum
  assign lrc_tx = 8'h00 - tx_chk.sum;

  always_comb begin
    logic       st_en;
    logic [7:0] st_b;
    logic       fin;
    logic       good;
    logic [4:0] nib;
    logic [4:0] wpos;
    logic [7:0] ckv;
    mfc_top_s   n;
    st_en = 1'b0;
    st_b = i_rx_data;
    fin = 1'b0;
    good = 1'b0;
    nib = asc2nib(i_rx_data);
    wpos = {q_r.widx, 1'b0};
    ckv = 8'h00;
    n = q_r;
    n.wr_valid = 1'b0;
    n.frame_ok = 1'b0;
    n.frame_bad = 1'b0;
    rx_chk.clr = 1'b0;
    tx_chk.clr = 1'b0;
    // (RULE13) idle time since last char
    if (i_rx_valid) n.gap = '0;
    else if (q_r.gap != GAP_END) n.gap = q_r.gap + 1'b1;
    unique case (q_r.st)
      S_RX: begin
        if (i_mode_rtu) begin
          if (i_rx_valid && (q_r.act || q_r.gap == GAP_END)) begin
            // (RULE13) byte after gap opens
            if (q_r.gap == GAP_END) begin
              rx_chk.clr = 1'b1;
              n.idx = '0;
              n.ovf = 1'b0;
              n.act = 1'b1;
            end
            st_en = 1'b1;
          end else if (!i_rx_valid && q_r.act && q_r.gap == GAP_END) begin
            fin = 1'b1;
          end
        end else if (i_rx_valid) begin
          // (RULE12) colon, hex pairs, CR LF
          if (i_rx_data == CH_COLON) begin
            rx_chk.clr = 1'b1;
            n.idx = '0;
            n.ovf = 1'b0;
            n.half = 1'b0;
            n.cr = 1'b0;
            n.act = 1'b1;
          end else if (!q_r.act) begin
            n.act = 1'b0;
          end else if (i_rx_data == CH_CR && !q_r.cr) begin
            n.cr = 1'b1;
          end else if (i_rx_data == CH_LF && q_r.cr) begin
            fin = 1'b1;
          end else if (nib[4] && !q_r.cr) begin
            n.half = !q_r.half;
            n.hin = nib[3:0];
            st_en = q_r.half;
            st_b = {q_r.hin, nib[3:0]};
          end else begin
            n.act = 1'b0;
            n.frame_bad = 1'b1;
          end
        end
        // Buffer full: keep counting nothing, mark frame bad later.
        // Index from n, since an RTU start clears it in this same cycle
        if (st_en) begin
          if (n.idx <= BUF_LAST) begin
            n.buf_b[n.idx] = st_b;
            n.idx = n.idx + 1'b1;
          end else begin
            n.ovf = 1'b1;
          end
        end
        // (RULE16) whole-frame residue check
        if (fin) begin
          n.act = 1'b0;
          if (i_mode_rtu)
            good = (q_r.idx >= MIN_RTU_LEN) && (rx_chk.crc == 16'h0000);
          else
            good = (q_r.idx >= MIN_ASC_LEN) && (rx_chk.sum == 8'h00) &&
                   !q_r.half;
          good = good && !q_r.ovf;
          n.frame_ok = good;
          n.frame_bad = !good;
          if (good && (q_r.buf_b[0] == i_station ||
                       q_r.buf_b[0] == BCAST_ADDR))
            n.st = S_EXEC;
        end
      end
      S_EXEC: begin
        // (RULE14) broadcast gets no reply
        n.bcast = (q_r.buf_b[0] == BCAST_ADDR);
        // (RULE15) words high byte first
        n.start = {q_r.buf_b[2], q_r.buf_b[3]};
        n.cnt = q_r.buf_b[5][3:0];
        n.widx = '0;
        n.len = ECHO_LEN;
        n.st = S_RX;
        if (q_r.buf_b[1] == FN_READ && q_r.buf_b[4] == 8'h00 &&
            q_r.buf_b[5] != 8'h00 && q_r.buf_b[5] <= MAX_RD_WDS &&
            !n.bcast) begin
          n.st = S_RD;
        end else if (q_r.buf_b[1] == FN_WRITE1) begin
          // (RULE10) single write, echo
          n.wr_valid = 1'b1;
          n.wr_addr = n.start;
          n.wr_data = {q_r.buf_b[4], q_r.buf_b[5]};
          n.st = n.bcast ? S_RX : (i_mode_rtu ? S_TDAT : S_TSOF);
          tx_chk.clr = !n.bcast;
        end else if (q_r.buf_b[1] == FN_WRITEN && q_r.buf_b[4] == 8'h00 &&
                     q_r.buf_b[5] != 8'h00 && q_r.buf_b[5] <= MAX_WR_WDS &&
                     q_r.buf_b[6] == {q_r.buf_b[5][6:0], 1'b0}) begin
          n.st = S_WR;
        end
      end
      S_WR: begin
        // (RULE11) one word per cycle
        n.wr_valid = 1'b1;
        n.wr_addr = q_r.start + {12'h000, q_r.widx};
        n.wr_data = {q_r.buf_b[WR_DATA_POS + wpos],
                     q_r.buf_b[WR_DATA_POS + wpos + 5'h01]};
        n.widx = q_r.widx + 1'b1;
        if (q_r.widx == q_r.cnt - 1'b1) begin
          n.st = q_r.bcast ? S_RX : (i_mode_rtu ? S_TDAT : S_TSOF);
          tx_chk.clr = !q_r.bcast;
        end
      end
      S_RD: begin
        n.rd_valid = 1'b1;
        n.rd_addr = q_r.start + {12'h000, q_r.widx};
        n.st = S_RDW;
      end
      S_RDW: begin
        // (RULE9) data packed after byte count
        n.rd_valid = 1'b0;
        n.buf_b[RD_DATA_POS + wpos] = i_rd_data[15:8];
        n.buf_b[RD_DATA_POS + wpos + 5'h01] = i_rd_data[7:0];
        n.widx = q_r.widx + 1'b1;
        n.st = S_RD;
        if (q_r.widx == q_r.cnt - 1'b1) begin
          n.buf_b[2] = {3'b000, q_r.cnt, 1'b0};
          n.len = RD_DATA_POS + {q_r.cnt, 1'b0};
          n.st = i_mode_rtu ? S_TDAT : S_TSOF;
          tx_chk.clr = 1'b1;
        end
      end
      S_TSOF: if (tx_take) n.st = S_TDAT;
      S_TDAT: if (tx_take) begin
        n.half = !i_mode_rtu && !q_r.half;
        if (i_mode_rtu || q_r.half) begin
          if (q_r.tpos == q_r.len - 1'b1) n.st = S_TCK;
          else n.tpos = q_r.tpos + 1'b1;
        end
      end
      S_TCK: if (tx_take) begin
        n.half = !i_mode_rtu && !q_r.half;
        n.ckb = i_mode_rtu && !q_r.ckb;
        if (!i_mode_rtu && q_r.half) n.st = S_TCR;
        else if (i_mode_rtu && q_r.ckb) n.st = S_RX;
      end
      S_TCR: if (tx_take) n.st = S_TLF;
      S_TLF: if (tx_take) n.st = S_RX;
    endcase
    if (n.st == S_RX) begin
      n.tpos = '0;
      n.ckb = 1'b0;
    end
    if (q_r.st != S_RX && n.st == S_RX) n.half = 1'b0;
    // Fold each reply byte as it is first shown, so the check settles
    // before the check characters are loaded
    tx_chk.en = (n.st == S_TDAT) &&
                (q_r.st != S_TDAT || q_r.tpos != n.tpos);
    tx_chk.data = n.buf_b[n.tpos];
    rx_chk.en = st_en;
    rx_chk.data = st_b;
    // (RULE8) CRC low then high
    if (i_mode_rtu) ckv = n.ckb ? tx_chk.crc[15:8] : tx_chk.crc[7:0];
    else ckv = lrc_tx;
    n.tx_valid = (n.st >= S_TSOF);
    unique case (n.st)
      S_TSOF:  n.tx_char = CH_COLON;
      S_TDAT:  n.tx_char = i_mode_rtu ? n.buf_b[n.tpos] :
                 nib2asc(n.half ? n.buf_b[n.tpos][3:0] :
                                  n.buf_b[n.tpos][7:4]);
      S_TCK:   n.tx_char = i_mode_rtu ? ckv :
                 nib2asc(n.half ? ckv[3:0] : ckv[7:4]);
      S_TCR:   n.tx_char = CH_CR;
      S_TLF:   n.tx_char = CH_LF;
      default: n.tx_char = 8'h00;
    endcase
    q_nxt = n;
  end

  // All-zero reset puts the machine in S_RX with the gap not yet seen
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) q_r <= '0;
    else q_r <= q_nxt;
  end

  assign o_tx_valid = q_r.tx_valid;
  assign o_tx_char = q_r.tx_char;
  assign o_wr_valid = q_r.wr_valid;
  assign o_wr_addr = q_r.wr_addr;
  assign o_wr_data = q_r.wr_data;
  assign o_rd_valid = q_r.rd_valid;
  assign o_rd_addr = q_r.rd_addr;
  assign o_frame_ok = q_r.frame_ok;
  assign o_frame_bad = q_r.frame_bad;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_bcast_silent: assert property (o_tx_valid |-> !q_r.bcast) // (RULE14)
    else $error("reply sent to broadcast");
  a_bad_discard: assert property (o_frame_bad |=>
    !o_wr_valid && !o_tx_valid && !o_rd_valid) // (RULE16)
    else $error("bad frame acted on");
  a_sof_colon: assert property (o_tx_valid && q_r.st == S_TSOF |->
    o_tx_char == CH_COLON) // (RULE12)
    else $error("reply not opened by colon");
  a_end_crlf: assert property (q_r.st == S_TCR && tx_take |=>
    q_r.st == S_TLF && o_tx_char == CH_LF) // (RULE12)
    else $error("CR not followed by LF");
  a_crc_low: assert property (o_tx_valid && q_r.st == S_TCK && i_mode_rtu &&
    !q_r.ckb |-> o_tx_char == tx_chk.crc[7:0]) // (RULE8)
    else $error("CRC low byte not first");
  a_crc_high: assert property (tx_take && q_r.st == S_TCK && i_mode_rtu &&
    !q_r.ckb |=> o_tx_char == tx_chk.crc[15:8]) // (RULE8)
    else $error("CRC high byte wrong");
  a_lrc_neg: assert property (o_tx_valid && q_r.st == S_TCK && !i_mode_rtu &&
    !q_r.half |-> o_tx_char == nib2asc(lrc_tx[7:4])) // (RULE2)
    else $error("LRC high char wrong");
  a_rtu_gap: assert property (o_frame_ok && i_mode_rtu |->
    q_r.gap == GAP_END) // (RULE13)
    else $error("RTU frame closed before gap");
  a_rd_order: assert property (q_r.st == S_RDW && q_r.widx == 4'h0 |=>
    q_r.buf_b[3] == $past(i_rd_data[15:8])) // (RULE15)
    else $error("read data not high byte first");
  a_wr_single: assert property (o_wr_valid && q_r.buf_b[1] == FN_WRITE1 |->
    o_wr_data == {q_r.buf_b[4], q_r.buf_b[5]}) // (RULE10)
    else $error("single write value wrong");
endmodule // mfc_frame_top

/* test/mfc_master_model.sv */
// Serial master model: frames requests, feeds them in, collects replies.
// Assumes the block's UART-side ports on one clock; drives 1 ns after edges.
`timescale 1ns/100ps
module mfc_master_model
  import mfc_pkg::*;
#(
  parameter int GAP = 20
)(
  input  wire logic       i_clk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_char,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  typedef logic [7:0] mfc_bq_t[$];
  logic [7:0] reply_q[$];
  logic       slow = 1'b0;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
  end

  function automatic logic [15:0] crc16(input mfc_bq_t b);
    logic [15:0] c;
    c = CRC_PRESET;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction

  function automatic mfc_bq_t frame(input logic rtu, input mfc_bq_t b);
    mfc_bq_t     f;
    logic [15:0] c;
    logic [7:0]  s;
    s = 8'h00;
    c = crc16(b);
    foreach (b[i]) s = s + b[i];
    s = -s;
    if (rtu) begin
      f = b;
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
    end else begin
      f.push_back(CH_COLON);
      b.push_back(s);
      foreach (b[i]) begin
        f.push_back(hexc(b[i][7:4]));
        f.push_back(hexc(b[i][3:0]));
      end
      f.push_back(CH_CR);
      f.push_back(CH_LF);
    end
    return f;
  endfunction

  // One char per pulse; released data line shows the inverse
  task automatic send(input mfc_bq_t f, input logic gap);
    if (gap) repeat (GAP + 4) @(posedge i_clk);
    foreach (f[i]) begin
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b1;
      o_rx_data  = f[i];
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b0;
      o_rx_data  = ~f[i];
    end
  endtask

  // Slow mode stalls every other cycle to stress the hold
  always @(posedge i_clk) begin
    #1;
    o_tx_ready = slow ? ~o_tx_ready : 1'b1;
  end

  // Take a char only at an edge where both sides agree
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1)
      reply_q.push_back(i_tx_char);
  end
endmodule // mfc_master_model

/* test/tb_modbus_frame_check_and_format.sv */
// Self-checking bench for the frame check and format block.
// Assumes the master model in test/ and a shortened RTU idle gap.
`timescale 1ns/100ps
module tb_modbus_frame_check_and_format;
  import mfc_pkg::*;
  typedef logic [7:0] mfc_bq_t[$];
  localparam int GAP = 20;
  logic        i_clk      = 1'b0;
  logic        i_reset    = 1'b1;
  logic        i_mode_rtu = 1'b1;
  logic [7:0]  i_station  = 8'h01;
  logic        i_rx_valid, i_tx_ready, o_tx_valid, o_wr_valid;
  logic        o_rd_valid, o_frame_ok, o_frame_bad;
  logic [7:0]  i_rx_data, o_tx_char;
  logic [15:0] o_wr_addr, o_wr_data, o_rd_addr, i_rd_data;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          n_ev     = 0;
  int          n_ok     = 0;
  logic [15:0] wr_a[$], wr_d[$], rd_a[$];

  mfc_frame_top #(.GAP_CYCLES(GAP)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_mode_rtu(i_mode_rtu),
    .i_station(i_station), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_char(o_tx_char),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .o_rd_valid(o_rd_valid),
    .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
    .o_frame_ok(o_frame_ok), .o_frame_bad(o_frame_bad));

  mfc_master_model #(.GAP(GAP)) master (
    .i_clk(i_clk), .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_tx_ready(i_tx_ready));

  always #20 i_clk = ~i_clk;
  // Register file stand-in answers in the same cycle
  assign i_rd_data = o_rd_addr ^ 16'h5aa5;

  // Record register traffic and frame verdicts; cut a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (o_wr_valid === 1'b1) begin
      wr_a.push_back(o_wr_addr);
      wr_d.push_back(o_wr_data);
    end
    if (o_rd_valid === 1'b1) rd_a.push_back(o_rd_addr);
    if (o_frame_ok === 1'b1 || o_frame_bad === 1'b1) n_ev++;
    if (o_frame_ok === 1'b1) n_ok++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask

  task automatic cmp_q(input mfc_bq_t got, input mfc_bq_t exp);
    check(16'(got.size()), 16'(exp.size()), "reply length");
    foreach (exp[i])
      if (i < got.size()) check({8'h00, got[i]}, {8'h00, exp[i]}, "char");
  endtask

  // Send one stream, wait for its verdict and any reply, then settle
  task automatic exch(input mfc_bq_t f, input int nrep, input logic good);
    int ev;
    int ok;
    ev = n_ev;
    ok = n_ok;
    master.reply_q.delete();
    wr_a.delete();
    wr_d.delete();
    rd_a.delete();
    master.send(f, i_mode_rtu);
    for (int k = 0; k < 3000 && (n_ev == ev ||
         master.reply_q.size() < nrep); k++)
      @(posedge i_clk);
    repeat (100) @(posedge i_clk);
    // Leave the edge before the caller touches the mode pin
    #1;
    check(16'(n_ev - ev), 16'h0001, "frame verdicts");
    check(16'(n_ok - ok), {15'h0000, good}, "frame good");
  endtask

  task automatic t_rtu_read();
    mfc_bq_t q, r;
    q = master.frame(1'b1, {8'h01, 8'h03, 8'h04, 8'h17, 8'h70, 8'h00, 8'h00});
    check({q[7], q[8]}, 16'hfe5c, "reference crc");
    master.slow = 1'b1;
    q = master.frame(1'b1, {8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02});
    check({q[6], q[7]}, 16'h6ff7, "request crc");
    exch(q, 9, 1'b1);
    check(16'(rd_a.size()), 16'h0002, "read count");
    check(rd_a[0], 16'h2102, "read addr 0");
    check(rd_a[1], 16'h2103, "read addr 1");
    r = {8'h01, 8'h03, 8'h04, 8'h21 ^ 8'h5a, 8'h02 ^ 8'ha5,
         8'h21 ^ 8'h5a, 8'h03 ^ 8'ha5};
    cmp_q(master.reply_q, master.frame(1'b1, r));
    master.slow = 1'b0;
  endtask

  task automatic t_rtu_write1();
    mfc_bq_t q;
    q = {8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70};
    exch(master.frame(1'b1, q), 8, 1'b1);
    check(wr_a[0], 16'h0100, "write addr");
    check(wr_d[0], 16'h1770, "write data");
    cmp_q(master.reply_q, {q, 8'h86, 8'h22});
  endtask

  task automatic t_asc_writen();
    mfc_bq_t q;
    i_mode_rtu = 1'b0;
    q = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04,
         8'h13, 8'h88, 8'h0f, 8'ha0};
    exch(master.frame(1'b0, q), 17, 1'b1);
    check(16'(wr_a.size()), 16'h0002, "write count");
    check(wr_a[1], 16'h0501, "second addr");
    check(wr_d[1], 16'h0fa0, "second data");
    q = {8'h3a, 8'h30, 8'h31, 8'h31, 8'h30, 8'h30, 8'h35, 8'h30, 8'h30,
         8'h30, 8'h30, 8'h30, 8'h32, 8'h45, 8'h38, 8'h0d, 8'h0a};
    cmp_q(master.reply_q, q);
    i_mode_rtu = 1'b1;
  endtask

  task automatic t_asc_read();
    mfc_bq_t q, r;
    i_mode_rtu = 1'b0;
    q = master.frame(1'b0, {8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01});
    check({q[13], q[14]}, 16'h4636, "reference lrc");
    exch(q, 15, 1'b1);
    check(16'(rd_a.size()), 16'h0001, "ascii read count");
    check(rd_a[0], 16'h0401, "ascii read addr");
    r = master.frame(1'b0, {8'h01, 8'h03, 8'h02, 8'h5e, 8'ha4});
    cmp_q(master.reply_q, r);
    i_mode_rtu = 1'b1;
  endtask

  task automatic t_bad_check();
    mfc_bq_t f;
    f = master.frame(1'b1, {8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70});
    f[6] = f[6] ^ 8'h01;
    exch(f, 0, 1'b0);
    check(16'(wr_a.size()), 16'h0000, "writes after bad crc");
    check(16'(master.reply_q.size()), 16'h0000, "reply");
  endtask

  task automatic t_bcast();
    mfc_bq_t f;
    f = master.frame(1'b1, {8'h00, 8'h06, 8'h20, 8'h00, 8'h00, 8'h02});
    exch(f, 0, 1'b1);
    check(wr_a[0], 16'h2000, "broadcast write");
    check(16'(master.reply_q.size()), 16'h0000, "reply");
  endtask

  task automatic t_no_gap();
    mfc_bq_t f;
    f = master.frame(1'b1, {8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70});
    exch({f, f}, 0, 1'b0);
    check(16'(wr_a.size()), 16'h0000, "writes of merged frame");
    check(16'(master.reply_q.size()), 16'h0000, "reply");
  endtask

  // Reset held 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    t_rtu_read();
    t_rtu_write1();
    t_asc_writen();
    t_asc_read();
    t_bad_check();
    t_bcast();
    t_no_gap();
    close_out();
  end
endmodule // tb_modbus_frame_check_and_format
